// ### dv/median_average_zone_filter_test.sv
// Self-checking bench for the median/average zone filter
module median_average_zone_filter_test
    import mzf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, smp_valid, smp_ready, flt_valid;
    logic irq, alert_n, wb_ack;
    logic [31:0] wb_dat, rd;
    mzf_smp_s smp, flt;
    mzf_wb_req_s wb_req = '0;
    int err_total = 0, cmp_count = 0, cyc_n = 0;
    mzf_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .smp_valid_i(smp_valid), .smp_i(smp), .smp_ready_o(smp_ready),
        .flt_valid_o(flt_valid), .flt_o(flt), .wb_i(wb_req),
        .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .irq_o(irq),
        .host_alert_pin_n_o(alert_n));
    mzf_conv_model u_conv (.clk_i(clk_i), .ready_i(smp_ready),
        .valid_o(smp_valid), .smp_o(smp));
    // 200 MHz clock
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end
    // Hang guard, far above the few hundred cycles needed
    always @(posedge clk_i)
    begin
        cyc_n++;
        if (cyc_n == 8000)
        begin
            err_total++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // Classic single cycle; held until ack is seen at an edge
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        wb_req <= '{cyc:1'b1, stb:1'b1, we:we, adr:a, sel:4'hF, dat:d};
        @(posedge clk_i);
        while (wb_ack !== 1'b1)
            @(posedge clk_i);
        rd = wb_dat;
        wb_req <= '0;
        @(posedge clk_i);
    endtask : wb
    task automatic burst(input logic [2:0] ch, input int n,
                         input int v0, input int st);
        for (int i = 0; i < n; i++)
            u_conv.q.push_back('{chan:ch, data:12'(v0 + i * st)});
    endtask : burst
    task automatic filt(input logic [2:0] ch, input logic [11:0] d);
        @(posedge clk_i);
        while (flt_valid !== 1'b1)
            @(posedge clk_i);
        cmp({17'h0, flt.chan, flt.data}, {17'h0, ch, d});
    endtask : filt
    task automatic t_regs();
        wb(1'b0, OFS_CTRL, 32'h0); cmp(rd, 32'h30);
        wb(1'b0, OFS_MASK, 32'h0); cmp(rd, 32'h7F);
        wb(1'b0, 8'hFC, 32'h0); cmp(rd, 32'h0);
    endtask : t_regs
    task automatic t_filters();
        burst(3'h0, 1, 12'h123, 0); filt(3'h0, 12'h123);
        wb(1'b0, OFS_RES, 32'h0); cmp(rd, 32'h123);
        wb(1'b1, OFS_CTRL, 32'h31); burst(3'h5, 4, 1, 1);
        filt(3'h5, (1 + 2 + 3 + 4) / 4);
        wb(1'b1, OFS_CTRL, 32'h33); burst(3'h1, 16, 0, 16);
        filt(3'h1, 12'd120);
        wb(1'b1, OFS_CTRL, 32'h34); burst(3'h2, 3, 9, -4);
        filt(3'h2, 12'd5);
        wb(1'b1, OFS_CTRL, 32'h39); burst(3'h6, 7, 300, -50);
        filt(3'h6, (100 + 150 + 200 + 150) / 4);
        wb(1'b1, OFS_CTRL, 32'h3E); burst(3'h3, 15, 14, -1);
        filt(3'h3, (4 + 5 + 6 + 7 + 8 + 9 + 10 + 7) / 8);
        wb(1'b1, OFS_CTRL, 32'h3A); burst(3'h0, 7, 0, 3);
        filt(3'h0, 12'd9);
        wb(1'b1, OFS_CTRL, 32'h35); burst(3'h1, 3, 7, -3);
        filt(3'h1, 12'd4);
        wb(1'b1, OFS_CTRL, 32'h3C); burst(3'h2, 15, 0, 5);
        filt(3'h2, 12'd35);
        wb(1'b1, OFS_CTRL, 32'h20); burst(3'h0, 1, 12'hABC, 0);
        filt(3'h0, 12'h2BC);
        wb(1'b1, OFS_CTRL, 32'h30);
    endtask : t_filters
    // One zone mode against a value on the high threshold
    task automatic zone_try(input int m, input logic hit);
        logic seen;
        wb(1'b1, OFS_STAT, 32'h7F);
        wb(1'b1, OFS_ZCFG, 32'((m << 4) | 1));
        burst(3'h4, 1, 12'h800, 0);
        seen = 1'b0;
        repeat (10)
        begin
            @(posedge clk_i);
            seen = seen | flt_valid;
        end
        cmp(32'(seen), 32'(hit));
        cmp({30'h0, irq, alert_n}, hit ? 32'h2 : 32'h1);
    endtask : zone_try
    task automatic t_zone();
        wb(1'b1, OFS_THR, 32'h800);
        wb(1'b1, OFS_THR + 8'h04, 32'h100);
        zone_try(2, 1'b0);
        zone_try(1, 1'b0);
        zone_try(0, 1'b1);
        wb(1'b0, OFS_STAT, 32'h0); cmp(rd, 32'h10);
        wb(1'b1, OFS_MASK, 32'h0); @(posedge clk_i);
        cmp(32'(irq), 32'h0);
        wb(1'b1, OFS_MASK, 32'h7F); @(posedge clk_i);
        cmp(32'(irq), 32'h1);
        wb(1'b1, OFS_STAT, 32'h10); @(posedge clk_i);
        cmp(32'(irq), 32'h0);
    endtask : t_zone
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_filters();
        t_zone();
        wrap_up();
    end
endmodule : median_average_zone_filter_test

// ### dv/mzf_conv_model.sv
// Converter model handing results to the filter one per handshake
module mzf_conv_model
    import mzf_pkg::*;
(
    // Clock and handshake
    input  wire logic clk_i,
    input  wire logic ready_i,
    output logic      valid_o,
    output mzf_smp_s  smp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    mzf_smp_s q[$];
    initial
    begin
        valid_o = 1'b0;
        smp_o   = '0;
    end
    // Hold each result until taken; idle data toggles so no stale match
    always @(posedge clk_i)
    begin
        if (!valid_o || ready_i)
        begin
            if (q.size() > 0)
            begin
                valid_o <= 1'b1;
                smp_o   <= q.pop_front();
            end
            else
            begin
                valid_o <= 1'b0;
                smp_o   <= ~smp_o;
            end
        end
    end
endmodule : mzf_conv_model

// ### src/mzf_pkg.sv
// Shared constants and types for the median/average zone filter
package mzf_pkg;

    // Data path sizes
    localparam int MZF_DW    = 12;
    localparam int MZF_DEPTH = 16;
    localparam int MZF_NCH   = 7;
    localparam int MZF_NZ    = 3;
    localparam int MZF_ZCH0  = 4;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ZCFG = 8'h04;
    localparam logic [7:0] OFS_THR  = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h20;
    localparam logic [7:0] OFS_MASK = 8'h24;
    localparam logic [7:0] OFS_RES  = 8'h40;

    // Field positions and widths
    localparam int CTRL_WIN  = 0;
    localparam int CTRL_MED  = 2;
    localparam int CTRL_RES  = 4;
    localparam int CTRL_AEN  = 5;
    localparam int CTRL_W    = 6;
    localparam int ZCFG_MODE = 4;
    localparam int ZCFG_W    = 10;

    // Values after reset
    localparam logic [5:0]  CTRL_RST   = 6'h30;
    localparam logic [9:0]  ZCFG_RST   = 10'h000;
    localparam logic [6:0]  MASK_RST   = 7'h7F;
    localparam logic [11:0] THR_HI_RST = 12'hFFF;
    localparam logic [11:0] THR_LO_RST = 12'h000;
    localparam logic [11:0] RES10_MASK = 12'h3FF;

    // Threshold zones
    typedef enum logic [1:0] {
        ZONE_ABOVE   = 2'h0,
        ZONE_BETWEEN = 2'h1,
        ZONE_BELOW   = 2'h2,
        ZONE_ALL     = 2'h3
    } mzf_zone_e;

    // Filter sequencing, one-hot
    typedef enum logic [2:0] {
        ST_COLLECT = 3'h1,
        ST_CALC    = 3'h2,
        ST_ZONE    = 3'h4
    } mzf_state_e;

    // Converter result with its channel
    typedef struct packed {
        logic [2:0]  chan;
        logic [11:0] data;
    } mzf_smp_s;

    // Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } mzf_wb_req_s;

endpackage : mzf_pkg

// ### src/mzf_sort.sv
// Insertion sorter holding the current set of converter results
module mzf_sort
    import mzf_pkg::*;
#(
    parameter int DW    = MZF_DW,
    parameter int DEPTH = MZF_DEPTH,
    parameter int CW    = $clog2(DEPTH + 1)
)(
    // Clock, reset, enable
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       ce_i,
    // Control and data in
    input  wire logic                       clr_i,
    input  wire logic                       ins_i,
    input  wire logic [DW-1:0]              dat_i,
    // Sorted contents
    output logic [DEPTH-1:0][DW-1:0]        srt_o,
    output logic [CW-1:0]                   cnt_o
);

    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] val;
        logic [CW-1:0]            cnt;
    } mzf_sort_s;

    mzf_sort_s                st_ff;
    mzf_sort_s                nxt_st;
    logic [DEPTH-1:0][DW-1:0] base;
    logic [CW-1:0]            bcnt;
    logic [CW-1:0]            pos;
    logic                     ordered;

    // Each new value slides into place, so the set is always ordered
    always_comb
    begin
        nxt_st = st_ff;
        base   = clr_i ? '0 : st_ff.val;
        bcnt   = clr_i ? '0 : st_ff.cnt;
        pos    = '0;
        for (int i = 0; i < DEPTH; i++)
        begin
            if (CW'(i) < bcnt && base[i] <= dat_i)
                pos = pos + 1'b1;
        end
        nxt_st.val = base;
        nxt_st.cnt = bcnt;
        if (ins_i && bcnt < CW'(DEPTH))
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                if (CW'(i) == pos)
                    nxt_st.val[i] = dat_i;
                else if (CW'(i) > pos)
                    nxt_st.val[i] = base[(i == 0) ? 0 : i - 1];
            end
            nxt_st.cnt = bcnt + 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_ff <= '0;
        else if (ce_i)
            st_ff <= nxt_st;
    end

    assign srt_o = st_ff.val;
    assign cnt_o = st_ff.cnt;

    // Helper for the ordering check
    always_comb
    begin
        ordered = 1'b1;
        for (int i = 0; i + 1 < DEPTH; i++)
        begin
            if (CW'(i + 1) < st_ff.cnt && st_ff.val[i] > st_ff.val[i + 1])
                ordered = 1'b0;
        end
    end

    a_sort_order: assert property (
        @(posedge clk_i) disable iff (rst_i) ordered)
        else $error("sorted set out of order");

endmodule : mzf_sort

// ### src/mzf_top.sv
// Median/average filter with threshold zones and Wishbone registers
// Overview of operation
// - Median one, window one: each converted result passes unchanged.
// - Median one, window above one: average exactly window-size results.
// - Collected results are kept sorted before any selection is made.
// - Median above one, window one: output the middle sorted result.
// - Both above one: average middle window, median counted twice.
// - Median code 00 to 11 selects set sizes 1, 3, 7, 15.
// - Window code gives 1,4,8,16 for median one; else 1,3,7.
// - Invalid combinations fall back to median only, keeping median size.
// - Filter serves every channel: touch, pressure, temperatures, auxiliary.
// - Zone detection keeps only results meeting the threshold condition.
// - Zones: at or above high, strictly between, at or below low.
// - Auxiliary and both temperatures have enabled thresholds; touch none.
// - A met zone drives the alert pin low and sets the flag.
// - Values are unsigned straight binary, ten or twelve bits wide.
// - The alert pin can serve as host interrupt for all events.
module mzf_top
    import mzf_pkg::*;
#(
    parameter int DW    = MZF_DW,
    parameter int DEPTH = MZF_DEPTH
)(
    // Clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Converter results
    input  wire logic        smp_valid_i,
    input  wire mzf_smp_s    smp_i,
    output logic             smp_ready_o,
    // Filtered results
    output logic             flt_valid_o,
    output mzf_smp_s         flt_o,
    // Wishbone slave
    input  wire mzf_wb_req_s wb_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Interrupt and alert pin
    output logic             irq_o,
    output logic             host_alert_pin_n_o
);

    localparam int CW = $clog2(DEPTH + 1);

    // Parameter check
    if (DEPTH != MZF_DEPTH || DW < 10 || DW > MZF_DW)
    begin : g_chk
        $error("mzf_top: DEPTH must be 16 and DW 10 to 12");
    end

    typedef struct packed {
        mzf_state_e                  state;
        logic [2:0]                  chan;
        logic [CTRL_W-1:0]           ctrl;
        logic [ZCFG_W-1:0]           zcfg;
        logic [MZF_NZ-1:0][DW-1:0]   thr_hi;
        logic [MZF_NZ-1:0][DW-1:0]   thr_lo;
        logic [MZF_NCH-1:0]          stat;
        logic [MZF_NCH-1:0]          mask;
        logic [MZF_NCH-1:0][DW-1:0]  res;
        logic [DW-1:0]               fval;
        logic                        fvld;
        logic                        ack;
        logic [31:0]                 rdat;
        logic                        irq;
        logic                        alert_n;
    } mzf_top_s;

    mzf_top_s                 st_ff;
    mzf_top_s                 nxt_st;
    logic [DEPTH-1:0][DW-1:0] srt;
    logic [CW-1:0]            scnt;
    logic [CW-1:0]            taken;
    logic [1:0]               med;
    logic [1:0]               weff;
    logic [4:0]               nset;
    logic [3:0]               mid;
    logic [3:0]               lo;
    logic [3:0]               hi;
    logic [2:0]               sh;
    logic [16:0]              sum;
    logic [DW-1:0]            avg;
    logic [DW-1:0]            sdat;
    logic                     acc;
    logic                     restart;
    logic                     zin;
    logic [1:0]               zi;
    logic                     zen_sel;
    logic                     zhit;
    logic                     keep;
    logic                     cvalid;
    logic                     wb_hit;
    logic [7:0]               aw;
    logic [31:0]              w32;
    logic [31:0]              rd;
    logic [MZF_NCH-1:0]       set;
    logic [MZF_NCH-1:0]       clr;
    logic [MZF_NCH-1:0]       pend;

    // Set size from the two codes
    function automatic logic [4:0] set_size(input logic [1:0] m,
                                            input logic [1:0] w);
        if (m == 2'h0)
            return (w == 2'h0) ? 5'h01 : (5'h02 << w);
        return 5'((5'h02 << m) - 5'h01);
    endfunction : set_size

    // Half-width of an odd set: codes 0..3 give 0, 1, 3, 7
    function automatic logic [3:0] half_idx(input logic [1:0] c);
        return 4'((5'h01 << c) - 5'h01);
    endfunction : half_idx

    // With a median above one, a window not below the median set is invalid, code 11 included
    function automatic logic [1:0] win_eff(input logic [1:0] m,
                                           input logic [1:0] w);
        return (m != 2'h0 && w >= m) ? 2'h0 : w;
    endfunction : win_eff

    // Bits of a word covered by the byte selects
    function automatic logic [31:0] lanes(input logic [3:0] sel);
        logic [31:0] l;
        l = '0;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
                l[8*b +: 8] = 8'hFF;
        end
        return l;
    endfunction : lanes

    // Byte-lane write of a register word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
        return (old & ~lanes(sel)) | (dat & lanes(sel));
    endfunction : merge

    // Sorted storage of the current set
    mzf_sort #(
        .DW    (DW),
        .DEPTH (DEPTH),
        .CW    (CW)
    ) u_sort (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .clr_i (restart || st_ff.state == ST_ZONE),
        .ins_i (acc),
        .dat_i (sdat),
        .srt_o (srt),
        .cnt_o (scnt)
    );

    // Threshold test for the channel just filtered
    mzf_zone #(
        .DW     (DW)
    ) u_zone (
        .val_i  (st_ff.fval),
        .hi_i   (st_ff.thr_hi[zi]),
        .lo_i   (st_ff.thr_lo[zi]),
        .mode_i (mzf_zone_e'(st_ff.zcfg[ZCFG_MODE + 2*zi +: 2])),
        .hit_o  (zhit)
    );

    // Sample intake; every channel code is accepted alike
    always_comb
    begin
        acc     = smp_valid_i && st_ff.state == ST_COLLECT;
        restart = acc && scnt != '0 && smp_i.chan != st_ff.chan;
        sdat    = st_ff.ctrl[CTRL_RES] ? smp_i.data[DW-1:0]
                : smp_i.data[DW-1:0] & RES10_MASK[DW-1:0];
        taken   = restart ? CW'(1) : scnt + 1'b1;
    end

    // Selection window and average over the sorted set
    always_comb
    begin
        med  = st_ff.ctrl[CTRL_MED +: 2];
        weff = win_eff(med, st_ff.ctrl[CTRL_WIN +: 2]);
        nset = set_size(med, weff);
        mid  = half_idx(med);
        lo   = (med == 2'h0) ? 4'h0 : mid - half_idx(weff);
        hi   = (med == 2'h0) ? 4'(nset - 5'h01)
             : mid + half_idx(weff);
        sum  = '0;
        for (int i = 0; i < MZF_DEPTH; i++)
        begin
            if (4'(i) >= lo && 4'(i) <= hi)
                sum = sum + 17'(srt[i]);
        end
        if (med != 2'h0)
            sum = sum + 17'(srt[mid]);
        // Divisor is W, or W+1 with the median doubled
        sh   = (med == 2'h0 && weff == 2'h0) ? 3'h0
             : 3'(weff) + 3'h1;
        avg  = DW'(sum >> sh);
    end

    // Zone channel lookup; touch channels never have zones
    always_comb
    begin
        cvalid  = st_ff.chan < 3'(MZF_NCH);
        zin     = st_ff.chan >= 3'(MZF_ZCH0) && cvalid;
        zi      = zin ? 2'(st_ff.chan - 3'(MZF_ZCH0)) : 2'h0;
        zen_sel = zin && st_ff.zcfg[zi];
        keep    = !zen_sel || zhit;
        wb_hit  = wb_i.cyc && wb_i.stb && !st_ff.ack;
        aw      = {wb_i.adr[7:2], 2'b00};
    end

    // Register read multiplexer, unmapped words read zero
    always_comb
    begin
        rd = '0;
        if (aw == OFS_CTRL)
            rd = 32'(st_ff.ctrl);
        if (aw == OFS_ZCFG)
            rd = 32'(st_ff.zcfg);
        if (aw == OFS_STAT)
            rd = 32'(st_ff.stat);
        if (aw == OFS_MASK)
            rd = 32'(st_ff.mask);
        for (int k = 0; k < MZF_NZ; k++)
        begin
            if (aw == 8'(OFS_THR + 8*k))
                rd = 32'(st_ff.thr_hi[k]);
            if (aw == 8'(OFS_THR + 8*k + 4))
                rd = 32'(st_ff.thr_lo[k]);
        end
        for (int c = 0; c < MZF_NCH; c++)
        begin
            if (aw == 8'(OFS_RES + 4*c))
                rd = 32'(st_ff.res[c]);
        end
    end

    // Next state: sequencing, register writes, flags, outputs
    always_comb
    begin
        nxt_st      = st_ff;
        nxt_st.ack  = 1'b0;
        nxt_st.fvld = 1'b0;
        set         = '0;
        clr         = '0;
        w32         = '0;
        case (st_ff.state)
            ST_COLLECT:
            begin
                if (acc)
                begin
                    nxt_st.chan = smp_i.chan;
                    if (taken >= CW'(nset))
                        nxt_st.state = ST_CALC;
                end
            end
            ST_CALC:
            begin
                nxt_st.fval  = avg;
                nxt_st.state = ST_ZONE;
            end
            ST_ZONE:
            begin
                if (keep && cvalid)
                begin
                    nxt_st.res[st_ff.chan] = st_ff.fval;
                    set[st_ff.chan]        = 1'b1;
                    nxt_st.fvld            = 1'b1;
                end
                nxt_st.state = ST_COLLECT;
            end
            default:
                nxt_st.state = ST_COLLECT;
        endcase
        // One access per request, answered the next cycle
        if (wb_hit)
        begin
            nxt_st.ack  = 1'b1;
            nxt_st.rdat = rd;
            if (wb_i.we)
            begin
                if (aw == OFS_CTRL)
                begin
                    w32         = merge(32'(st_ff.ctrl), wb_i.dat, wb_i.sel);
                    nxt_st.ctrl = w32[CTRL_W-1:0];
                end
                if (aw == OFS_ZCFG)
                begin
                    w32         = merge(32'(st_ff.zcfg), wb_i.dat, wb_i.sel);
                    nxt_st.zcfg = w32[ZCFG_W-1:0];
                end
                if (aw == OFS_MASK)
                begin
                    w32         = merge(32'(st_ff.mask), wb_i.dat, wb_i.sel);
                    nxt_st.mask = w32[MZF_NCH-1:0];
                end
                if (aw == OFS_STAT)
                begin
                    w32 = wb_i.dat & lanes(wb_i.sel);
                    clr = w32[MZF_NCH-1:0];
                end
                for (int k = 0; k < MZF_NZ; k++)
                begin
                    if (aw == 8'(OFS_THR + 8*k))
                    begin
                        w32 = merge(32'(st_ff.thr_hi[k]), wb_i.dat, wb_i.sel);
                        nxt_st.thr_hi[k] = w32[DW-1:0];
                    end
                    if (aw == 8'(OFS_THR + 8*k + 4))
                    begin
                        w32 = merge(32'(st_ff.thr_lo[k]), wb_i.dat, wb_i.sel);
                        nxt_st.thr_lo[k] = w32[DW-1:0];
                    end
                end
            end
        end
        // New events win over a clear in the same cycle
        nxt_st.stat    = (st_ff.stat & ~clr) | set;
        pend           = nxt_st.stat & nxt_st.mask;
        nxt_st.irq     = |pend;
        nxt_st.alert_n = !(nxt_st.ctrl[CTRL_AEN] && |pend);
    end

    // State register; reset gives a quiet pin and an empty set
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff         <= '0;
            st_ff.state   <= ST_COLLECT;
            st_ff.ctrl    <= CTRL_RST;
            st_ff.zcfg    <= ZCFG_RST;
            st_ff.mask    <= MASK_RST;
            st_ff.thr_hi  <= {MZF_NZ{THR_HI_RST[DW-1:0]}};
            st_ff.thr_lo  <= {MZF_NZ{THR_LO_RST[DW-1:0]}};
            st_ff.alert_n <= 1'b1;
        end
        else if (ce_i)
            st_ff <= nxt_st;
    end

    // Outputs straight from the state register
    assign smp_ready_o        = st_ff.state[0];
    assign flt_valid_o        = st_ff.fvld;
    assign flt_o              = {st_ff.chan, 12'(st_ff.fval)};
    assign wb_dat_o           = st_ff.rdat;
    assign wb_ack_o           = st_ff.ack;
    assign irq_o              = st_ff.irq;
    assign host_alert_pin_n_o = st_ff.alert_n;

    a_bypass_pass: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && st_ff.state == ST_CALC && med == 2'h0 && weff == 2'h0
        |=> st_ff.fval == $past(srt[0]))
        else $error("bypass did not pass the single result");

    a_median_pick: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && st_ff.state == ST_CALC && med == 2'h3 && weff == 2'h0
        |=> st_ff.fval == $past(srt[7]))
        else $error("median of fifteen is not entry seven");

    a_avg_double: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && st_ff.state == ST_CALC && med == 2'h2
            && st_ff.ctrl[CTRL_WIN +: 2] == 2'h1
        |=> 17'(st_ff.fval) == (($past(17'(srt[2])) + $past(17'(srt[3]))
            + $past(17'(srt[3])) + $past(17'(srt[4]))) >> 2))
        else $error("middle three of seven averaged wrongly");

    a_fallback_med: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && st_ff.state == ST_CALC && med == 2'h1
            && st_ff.ctrl[CTRL_WIN +: 2] != 2'h0
        |=> st_ff.fval == $past(srt[1]))
        else $error("invalid window did not fall back to median");

    a_collect_count: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && st_ff.state == ST_CALC && med == 2'h0
        |-> scnt == CW'(nset))
        else $error("set size differs from selected window");

    a_zone_drop: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && st_ff.state == ST_ZONE && zen_sel && !zhit
        |=> $stable(st_ff.res) && !flt_valid_o)
        else $error("result outside zone was kept");

    a_free_store: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && st_ff.state == ST_ZONE && !zen_sel && cvalid
        |=> st_ff.res[$past(st_ff.chan)] == $past(st_ff.fval)
            && st_ff.stat[$past(st_ff.chan)] && flt_valid_o)
        else $error("unscreened result not stored and flagged");

    a_alert_low: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && st_ff.state == ST_ZONE && zen_sel && zhit && !wb_hit
            && st_ff.ctrl[CTRL_AEN] && st_ff.mask[st_ff.chan]
        |=> !host_alert_pin_n_o && irq_o)
        else $error("zone hit did not pull the alert pin low");

    a_ack_pulse: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && wb_i.cyc && wb_i.stb && !wb_ack_o
        |=> wb_ack_o ##1 (!wb_ack_o || !ce_i))
        else $error("bus answer is not a single-cycle ack");

endmodule : mzf_top

// ### src/mzf_zone.sv
// Threshold zone comparator for one filtered value
module mzf_zone
    import mzf_pkg::*;
#(
    parameter int DW = MZF_DW
)(
    // Value and thresholds
    input  wire logic [DW-1:0] val_i,
    input  wire logic [DW-1:0] hi_i,
    input  wire logic [DW-1:0] lo_i,
    input  wire mzf_zone_e     mode_i,
    // Result
    output logic               hit_o
);

    // Zone test; inclusive at the outer limits, strict inside
    always_comb
    begin
        case (mode_i)
            ZONE_ABOVE:   hit_o = val_i >= hi_i;
            ZONE_BETWEEN: hit_o = (val_i > lo_i) && (val_i < hi_i);
            ZONE_BELOW:   hit_o = val_i <= lo_i;
            default:      hit_o = 1'b1;
        endcase
    end

endmodule : mzf_zone
